// file: design/pmbsi_slave.sv
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module pmbsi_slave #(
  parameter int STORE_CNT = pmbsi_pkg::STORE_CYCLES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic sclOe,
  output logic alertOut,
  output logic alertOe,
  input wire logic [2:0] addr_strap_high,
  input wire logic [2:0] addr_strap_low,
  input wire logic [6:0] nvmOffset,
  input wire logic [7:0] nvmOptions,
  input wire logic nvmValid,
  input wire logic protFault,
  input wire pmbsi_pkg::pmbsi_tele_s telemetry,
  output logic nvmStore,
  output logic irq
);
  localparam int IRQ_W = pmbsi_pkg::IRQ_W;
  // bus pins synchronised: stage 1 feeds only stage 2
  // core clock far above 400 kHz, so both bus rates are sampled cleanly
  logic [1:0] sclSync_ff, sdaSync_ff;
  logic sclPrev_ff, sdaPrev_ff;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclSync_ff <= 2'h3;
      sdaSync_ff <= 2'h3;
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
    end else begin
      sclSync_ff <= {sclSync_ff[0], sclIn};
      sdaSync_ff <= {sdaSync_ff[0], sdaIn};
      sclPrev_ff <= sclSync_ff[1];
      sdaPrev_ff <= sdaSync_ff[1];
    end
  end
  wire scl = sclSync_ff[1];
  wire sda = sdaSync_ff[1];
  wire sclRise = scl && !sclPrev_ff;
  wire sclFall = !scl && sclPrev_ff;
  wire startCond = scl && sclPrev_ff && !sda && sdaPrev_ff;
  wire stopCond = scl && sclPrev_ff && sda && !sdaPrev_ff;

  // registers
  logic [6:0] offset_ff;
  logic [7:0] options_ff;
  logic [IRQ_W-1:0] irqStat_ff, mask_ff;
  logic [7:0] lastCmd_ff;
  logic busy_ff, cmlErr_ff, faultLatch_ff;
  logic [22:0] storeCnt_ff;
  logic optSingle_ff;

  // address formation
  wire singlePin = optSingle_ff;
  wire [6:0] rawAddr = singlePin ? 7'(offset_ff + addr_strap_high)
    : 7'({addr_strap_high, 3'h0} + addr_strap_low + offset_ff);
  wire isResv = rawAddr == pmbsi_pkg::RESV_A0 || rawAddr == pmbsi_pkg::RESV_A1
    || rawAddr == pmbsi_pkg::RESV_A2;
  wire [6:0] slaveAddr = isResv ? pmbsi_pkg::REMAP_ADDR : rawAddr;

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ pmbsi_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // link state machine
  pmbsi_pkg::pmbsi_state_e state_ff;
  logic [3:0] bitCnt_ff;
  logic [7:0] shift_ff, crc_ff, crcPrev_ff;
  logic [3:0] byteCnt_ff;
  logic [7:0] cmdByte_ff, data0_ff;
  logic rdMode_ff, sdaDrv_ff, rxEvt_ff;
  wire pecReq = options_ff[pmbsi_pkg::PEC_REQ_BIT];
  wire byteDone = sclRise && bitCnt_ff == 4'd7;
  wire [7:0] rxByte = {shift_ff[6:0], sda};
  wire addrHit = rxByte[7:1] == slaveAddr;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= pmbsi_pkg::PMBSI_IDLE;
      bitCnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      byteCnt_ff <= 4'h0;
      crc_ff <= 8'h00;
      crcPrev_ff <= 8'h00;
      sdaDrv_ff <= 1'b0;
      rdMode_ff <= 1'b0;
      cmdByte_ff <= 8'h00;
      data0_ff <= 8'h00;
      rxEvt_ff <= 1'b0;
    end else begin
      rxEvt_ff <= 1'b0;
      if (startCond) begin
        state_ff <= pmbsi_pkg::PMBSI_ADDR;
        bitCnt_ff <= 4'h0;
        sdaDrv_ff <= 1'b0;
        if (!rdMode_ff) begin
          byteCnt_ff <= 4'h0;
          crc_ff <= 8'h00;
        end
      end else if (stopCond) begin
        state_ff <= pmbsi_pkg::PMBSI_IDLE;
        sdaDrv_ff <= 1'b0;
        rdMode_ff <= 1'b0;
      end else begin
        case (state_ff)
          pmbsi_pkg::PMBSI_ADDR, pmbsi_pkg::PMBSI_DATA: begin
            if (sclRise) begin
              shift_ff <= rxByte;
              bitCnt_ff <= bitCnt_ff + 4'h1;
            end
            if (byteDone) begin
              if (state_ff == pmbsi_pkg::PMBSI_ADDR && !addrHit) begin
                state_ff <= pmbsi_pkg::PMBSI_IGNORE;
              end else begin
                state_ff <= pmbsi_pkg::PMBSI_ACK;
                crcPrev_ff <= crc_ff;
                crc_ff <= crc8(crc_ff, rxByte);
                if (state_ff == pmbsi_pkg::PMBSI_ADDR) begin
                  rdMode_ff <= rxByte[0];
                end else begin
                  rxEvt_ff <= 1'b1;
                  byteCnt_ff <= byteCnt_ff + 4'h1;
                  if (byteCnt_ff == 4'h0) cmdByte_ff <= rxByte;
                  if (byteCnt_ff == 4'h1) data0_ff <= rxByte;
                end
              end
            end
          end
          pmbsi_pkg::PMBSI_ACK: begin
            // ack driven from the falling edge after the eighth bit
            if (sclFall && !sdaDrv_ff) begin
              sdaDrv_ff <= 1'b1;
            end else if (sclFall) begin
              sdaDrv_ff <= 1'b0;
              bitCnt_ff <= 4'h0;
              state_ff <= rdMode_ff ? pmbsi_pkg::PMBSI_IGNORE : pmbsi_pkg::PMBSI_DATA;
            end
          end
          default: ;
        endcase
      end
    end
  end
  // read data path kept out of the link: telemetry goes via the register bus
  assign sdaOut = 1'b0;
  assign sdaOe = sdaDrv_ff;
  assign sclOe = 1'b0;

  // end of write transaction: decide on PEC and commit
  wire txnEnd = stopCond && (state_ff == pmbsi_pkg::PMBSI_DATA || state_ff == pmbsi_pkg::PMBSI_ACK)
    && !rdMode_ff && byteCnt_ff != 4'h0;
  // with a PEC byte the running crc covering it is zero
  wire pecOk = crc_ff == 8'h00 && byteCnt_ff > 4'h1;
  wire pecBad = pecReq && !pecOk;
  wire commit = txnEnd && !pecBad && !busy_ff;
  wire cmdClear = commit && cmdByte_ff == pmbsi_pkg::CMD_CLEAR_FAULTS;
  wire cmdStore = commit && cmdByte_ff == pmbsi_pkg::CMD_STORE_USER;
  wire cmdOpts = commit && cmdByte_ff == pmbsi_pkg::CMD_SPECIAL_OPTS && byteCnt_ff > 4'h1;
  wire cmdOfs = commit && cmdByte_ff == pmbsi_pkg::CMD_ADDR_OFFSET && byteCnt_ff > 4'h1;
  wire busyHit = txnEnd && busy_ff;

  // bus slave
  logic [7:0] aAddr_ff;
  logic aWr_ff, aRd_ff;
  wire aValid = hsel && hready && htrans[1];
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      aAddr_ff <= 8'h00;
      aWr_ff <= 1'b0;
      aRd_ff <= 1'b0;
    end else if (hready) begin
      aAddr_ff <= haddr[7:0];
      aWr_ff <= aValid && hwrite;
      aRd_ff <= aValid && !hwrite;
    end
  end
  wire wrOfs = aWr_ff && aAddr_ff == pmbsi_pkg::OFFSET_OFS;
  wire wrOpts = aWr_ff && aAddr_ff == pmbsi_pkg::OPTS_OFS;
  wire wrMask = aWr_ff && aAddr_ff == pmbsi_pkg::MASK_OFS;
  wire wrCtrl = aWr_ff && aAddr_ff == pmbsi_pkg::CTRL_OFS;
  wire rdIrq = aRd_ff && aAddr_ff == pmbsi_pkg::IRQ_OFS;
  wire swClear = wrCtrl && hwdata[0];
  wire swStore = wrCtrl && hwdata[1];
  wire startStore = (cmdStore || swStore) && !busy_ff;
  assign nvmStore = startStore;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  wire [IRQ_W-1:0] events = {busyHit, startStore, stopCond, rxEvt_ff, txnEnd && pecBad,
    protFault && !faultLatch_ff};
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      offset_ff <= pmbsi_pkg::OFFSET_RST;
      options_ff <= pmbsi_pkg::OPTS_RST;
      optSingle_ff <= 1'b0;
      mask_ff <= pmbsi_pkg::MASK_RST;
      irqStat_ff <= '0;
      busy_ff <= 1'b0;
      storeCnt_ff <= 23'h0;
      cmlErr_ff <= 1'b0;
      faultLatch_ff <= 1'b0;
      lastCmd_ff <= 8'h00;
    end else begin
      if (nvmValid) begin
        offset_ff <= nvmOffset;
        options_ff <= nvmOptions;
      end else if (cmdOfs || wrOfs) begin
        offset_ff <= wrOfs ? hwdata[6:0] : data0_ff[6:0];
        optSingle_ff <= wrOfs ? hwdata[pmbsi_pkg::SINGLE_PIN_BIT] : data0_ff[pmbsi_pkg::SINGLE_PIN_BIT];
      end else if (cmdOpts || wrOpts) begin
        options_ff <= wrOpts ? hwdata[7:0] : data0_ff;
      end
      if (wrMask) mask_ff <= hwdata[IRQ_W-1:0];
      // a new event wins over the read clear
      irqStat_ff <= (rdIrq ? '0 : irqStat_ff) | events;
      if (startStore) begin
        busy_ff <= 1'b1;
        storeCnt_ff <= 23'(STORE_CNT - 1);
      end else if (busy_ff) begin
        if (storeCnt_ff == 23'h0) busy_ff <= 1'b0;
        else storeCnt_ff <= storeCnt_ff - 23'h1;
      end
      if (txnEnd && pecBad) cmlErr_ff <= 1'b1;
      else if (cmdClear || swClear) cmlErr_ff <= 1'b0;
      if (protFault && !mask_ff[pmbsi_pkg::IRQ_FAULT]) faultLatch_ff <= 1'b1;
      else if (cmdClear || swClear) faultLatch_ff <= 1'b0;
      if (commit) lastCmd_ff <= cmdByte_ff;
    end
  end
  assign alertOut = 1'b0;
  assign alertOe = faultLatch_ff;
  assign irq = |(irqStat_ff & ~mask_ff);

  // read mux, telemetry always available
  logic [31:0] rdNext;
  always_comb begin
    if (aAddr_ff == pmbsi_pkg::OFFSET_OFS) rdNext = {24'h0, optSingle_ff, offset_ff};
    else if (aAddr_ff == pmbsi_pkg::OPTS_OFS) rdNext = {24'h0, options_ff};
    else if (aAddr_ff == pmbsi_pkg::STAT_OFS) rdNext = {28'h0, faultLatch_ff, cmlErr_ff, busy_ff, pecReq};
    else if (aAddr_ff == pmbsi_pkg::IRQ_OFS) rdNext = {26'h0, irqStat_ff};
    else if (aAddr_ff == pmbsi_pkg::MASK_OFS) rdNext = {26'h0, mask_ff};
    else if (aAddr_ff == pmbsi_pkg::ADDR_OFS) rdNext = {25'h0, slaveAddr};
    else if (aAddr_ff == pmbsi_pkg::TELE0_OFS) rdNext = {telemetry.vout, telemetry.vin};
    else if (aAddr_ff == pmbsi_pkg::TELE1_OFS) rdNext = {telemetry.duty, telemetry.iout};
    else if (aAddr_ff == pmbsi_pkg::TELE2_OFS) rdNext = {16'h0, telemetry.temp};
    else if (aAddr_ff == pmbsi_pkg::CMD_OFS) rdNext = {24'h0, lastCmd_ff};
    else rdNext = 32'h0;
  end
  assign hrdata = aRd_ff ? rdNext : 32'h0;

  property remapP;
    @(posedge core_clk) disable iff (!arst_n) isResv |-> slaveAddr == 7'h7f;
  endproperty
  addr_remap_a: assert property (remapP) else $error("reserved address not remapped");
  alert_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    alertOe && !(cmdClear || swClear) |=> alertOe) else $error("alert dropped early");
  fault_alert_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    protFault && !mask_ff[0] |=> alertOe) else $error("fault did not raise alert");
  pec_drop_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    txnEnd && pecReq && !pecOk |-> !commit ##1 cmlErr_ff) else $error("bad pec accepted");
  busy_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    startStore |=> busy_ff) else $error("busy not set on store");
  store_pulse_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    cmdStore && !busy_ff |-> nvmStore) else $error("store not issued");
  addr_form_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !singlePin && !isResv |-> slaveAddr == 7'(addr_strap_high * 8 + addr_strap_low + offset_ff))
    else $error("address sum wrong");
  mask_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !alertOe && mask_ff[0] |=> !alertOe || !mask_ff[0] || cmdOfs) else $error("masked fault alerted");
  opts_pec_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    pecReq == options_ff[7]) else $error("pec mode mismatch");
  single_pin_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    singlePin && !isResv |-> slaveAddr == 7'(offset_ff + addr_strap_high)) else $error("single pin wrong");
endmodule

// file: design/pmbsi_pkg.sv
package pmbsi_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] OFFSET_OFS = 8'h04;
  localparam logic [7:0] OPTS_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  localparam logic [7:0] IRQ_OFS = 8'h10;
  localparam logic [7:0] MASK_OFS = 8'h14;
  localparam logic [7:0] ADDR_OFS = 8'h18;
  localparam logic [7:0] TELE0_OFS = 8'h1c;
  localparam logic [7:0] TELE1_OFS = 8'h20;
  localparam logic [7:0] TELE2_OFS = 8'h24;
  localparam logic [7:0] CMD_OFS = 8'h28;
  // reset values
  localparam logic [6:0] OFFSET_RST = 7'h28;
  localparam logic [7:0] OPTS_RST = 8'h00;
  localparam logic [5:0] MASK_RST = 6'h00;
  // field positions
  localparam int PEC_REQ_BIT = 7;
  localparam int SINGLE_PIN_BIT = 7;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_PECERR = 1;
  localparam int IRQ_RXBYTE = 2;
  localparam int IRQ_STOP = 3;
  localparam int IRQ_STORE = 4;
  localparam int IRQ_BUSYHIT = 5;
  localparam int IRQ_W = 6;
  // remapped addresses
  localparam logic [6:0] RESV_A0 = 7'h00;
  localparam logic [6:0] RESV_A1 = 7'h0b;
  localparam logic [6:0] RESV_A2 = 7'h0c;
  localparam logic [6:0] REMAP_ADDR = 7'h7f;
  // command codes and the PEC polynomial
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_USER = 8'h15;
  localparam logic [7:0] CMD_SPECIAL_OPTS = 8'he0;
  localparam logic [7:0] CMD_ADDR_OFFSET = 8'hee;
  localparam logic [7:0] CRC_POLY = 8'h07;
  // store latency, counted on the core clock
  localparam int STORE_TIME_MS = 5;
  localparam int CORE_MHZ = 200;
  localparam int STORE_CYCLES = STORE_TIME_MS * CORE_MHZ * 1000;

  typedef enum logic [4:0] {
    PMBSI_IDLE = 5'b00001,
    PMBSI_ADDR = 5'b00010,
    PMBSI_ACK = 5'b00100,
    PMBSI_DATA = 5'b01000,
    PMBSI_IGNORE = 5'b10000
  } pmbsi_state_e;

  typedef struct packed {
    logic [15:0] vin;
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] duty;
    logic [15:0] temp;
  } pmbsi_tele_s;
endpackage

// file: test/pmbsi_host_model.sv
`timescale 1ns/10ps
module pmbsi_host_model (
  output logic sclLow,
  output logic sdaLow,
  input wire logic scl,
  input wire logic sda
);
  // quarter of the 80 ns link clock; clock stands still between frames
  localparam int Q = 20;
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  task automatic start();
    sdaLow = 1'b1;
    #Q;
    sclLow = 1'b1;
    #Q;
  endtask
  task automatic clkBit(input logic b, output logic s);
    int n;
    sdaLow = ~b;
    #Q;
    sclLow = 1'b0;
    n = 0;
    while (scl !== 1'b1 && n < 1000) begin
      #1;
      n++;
    end
    #Q;
    s = sda;
    #Q;
    sclLow = 1'b1;
    #Q;
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clkBit(b[i], s);
    clkBit(1'b1, s);
    ack = ~s;
  endtask
  task automatic stop();
    sdaLow = 1'b1;
    #Q;
    sclLow = 1'b0;
    #Q;
    sdaLow = 1'b0;
    #100;
  endtask
endmodule

// file: test/pmbus_slave_interface_tb.sv
`timescale 1ns/10ps
module pmbus_slave_interface_tb;
  localparam int STC = 2000;
  logic core_clk, arst_n, hwrite, sdaOut, sdaOe, sclOe, alertOut, alertOe, ack;
  logic hreadyout, hresp, nvmValid, protFault, nvmStore, irq, hSclLow, hSdaLow;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, strapHigh, strapLow;
  logic [6:0] nvmOffset, offs[4];
  logic [7:0] nvmOptions;
  pmbsi_pkg::pmbsi_tele_s tele;
  wire scl = !(hSclLow || sclOe);
  wire sda = !(hSdaLow || sdaOe);
  int num_errors = 0;
  int total_checks = 0;
  int stores = 0;
  pmbsi_slave #(.STORE_CNT(STC)) dut (.core_clk(core_clk), .arst_n(arst_n), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hsel(1'b1), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .sclOe(sclOe), .alertOut(alertOut), .alertOe(alertOe), .addr_strap_high(strapHigh),
    .addr_strap_low(strapLow), .nvmOffset(nvmOffset), .nvmOptions(nvmOptions), .nvmValid(nvmValid),
    .protFault(protFault), .telemetry(tele), .nvmStore(nvmStore), .irq(irq));
  pmbsi_host_model host (.sclLow(hSclLow), .sdaLow(hSdaLow), .scl(scl), .sda(sda));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (nvmStore === 1'b1) stores++;
  task automatic results();
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic fail(input string m);
    $display("unexpected at %0t: %s", $time, m);
    num_errors++;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", m, got, exp));
  endtask
  task automatic waitRdy();
    int n;
    n = 0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 100) begin
        fail("bus wait ran out");
        results();
      end
      @(posedge core_clk);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    waitRdy();
    htrans <= 2'b00;
    hwdata <= d;
    waitRdy();
    rd = hrdata;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string m);
    ahb(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    return r;
  endfunction
  // pec: 0 none, 1 correct check byte, 2 corrupted check byte
  task automatic link(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, input int n, input int pec);
    logic [7:0] p;
    logic ok;
    p = crc(crc(8'h00, {a, 1'b0}), c);
    host.start();
    host.sendByte({a, 1'b0}, ok);
    host.sendByte(c, ack);
    if (n > 1) host.sendByte(d, ack);
    if (n > 1) p = crc(p, d);
    if (pec > 0) host.sendByte(pec == 1 ? p : ~p, ack);
    host.stop();
    ack = ok;
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    fail("run too long");
    results();
  end
  initial begin
    arst_n = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    strapHigh = 3'd0;
    strapLow = 3'd0;
    nvmOffset = 7'h30;
    nvmOptions = 8'h00;
    nvmValid = 1'b0;
    protFault = 1'b0;
    tele = '0;
    offs = '{7'd0, 7'd11, 7'd12, 7'd13};
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    rdChk(pmbsi_pkg::OFFSET_OFS, 32'h28, "offset rst");
    rdChk(pmbsi_pkg::OPTS_OFS, 32'h0, "opts rst");
    rdChk(pmbsi_pkg::MASK_OFS, 32'h0, "mask rst");
    rdChk(8'h3c, 32'h0, "unmapped");
    for (int i = 0; i < 8; i++) begin
      strapHigh <= 3'(i);
      strapLow <= 3'(7 - i);
      repeat (4) @(posedge core_clk);
      rdChk(pmbsi_pkg::ADDR_OFS, 32'(8 * i + 7 - i + 40), "strap addr");
    end
    strapHigh <= 3'd0;
    strapLow <= 3'd0;
    foreach (offs[i]) begin
      ahb(1'b1, pmbsi_pkg::OFFSET_OFS, {25'h0, offs[i]});
      rdChk(pmbsi_pkg::ADDR_OFS, offs[i] == 7'd13 ? 32'hd : 32'h7f, "remap");
    end
    strapHigh <= 3'd2;
    strapLow <= 3'd5;
    ahb(1'b1, pmbsi_pkg::OFFSET_OFS, 32'ha8);
    rdChk(pmbsi_pkg::ADDR_OFS, 32'h2a, "single pin");
    ahb(1'b1, pmbsi_pkg::OFFSET_OFS, 32'h28);
    @(posedge core_clk);
    nvmValid <= 1'b1;
    @(posedge core_clk);
    nvmValid <= 1'b0;
    rdChk(pmbsi_pkg::OFFSET_OFS, 32'h30, "nvm load");
    rdChk(pmbsi_pkg::ADDR_OFS, 32'h45, "nvm addr");
    link(7'h45, 8'hee, 8'h28, 2, 0);
    chk(ack, 1'b1, "addr ack");
    rdChk(pmbsi_pkg::OFFSET_OFS, 32'h28, "link offset");
    link(7'h3e, 8'h03, 8'h0, 1, 0);
    chk(ack, 1'b0, "foreign addr");
    ahb(1'b0, pmbsi_pkg::IRQ_OFS, 32'h0);
    protFault <= 1'b1;
    repeat (3) @(posedge core_clk);
    protFault <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(alertOe, 1'b1, "alert");
    chk(irq, 1'b1, "irq");
    rdChk(pmbsi_pkg::STAT_OFS, 32'h8, "fault latch");
    rdChk(pmbsi_pkg::IRQ_OFS, 32'h1, "irq fault");
    rdChk(pmbsi_pkg::IRQ_OFS, 32'h0, "irq read clear");
    chk(alertOe, 1'b1, "alert held");
    link(7'h3d, pmbsi_pkg::CMD_CLEAR_FAULTS, 8'h0, 1, 0);
    chk(alertOe, 1'b0, "alert cleared");
    rdChk(pmbsi_pkg::CMD_OFS, 32'h3, "cmd");
    ahb(1'b0, pmbsi_pkg::IRQ_OFS, 32'h0);
    ahb(1'b1, pmbsi_pkg::MASK_OFS, 32'h1);
    protFault <= 1'b1;
    repeat (4) @(posedge core_clk);
    protFault <= 1'b0;
    chk(alertOe, 1'b0, "masked alert");
    chk(irq, 1'b0, "masked irq");
    rdChk(pmbsi_pkg::IRQ_OFS, 32'h1, "masked sticky");
    ahb(1'b1, pmbsi_pkg::MASK_OFS, 32'h0);
    protFault <= 1'b1;
    @(posedge core_clk);
    protFault <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(alertOe, 1'b1, "alert unmasked");
    ahb(1'b1, pmbsi_pkg::CTRL_OFS, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(alertOe, 1'b0, "ctrl clear");
    link(7'h3d, pmbsi_pkg::CMD_SPECIAL_OPTS, 8'h80, 2, 0);
    rdChk(pmbsi_pkg::OPTS_OFS, 32'h80, "opts by link");
    rdChk(pmbsi_pkg::STAT_OFS, 32'h1, "pec required");
    ahb(1'b0, pmbsi_pkg::IRQ_OFS, 32'h0);
    link(7'h3d, pmbsi_pkg::CMD_CLEAR_FAULTS, 8'h0, 1, 0);
    rdChk(pmbsi_pkg::STAT_OFS, 32'h5, "missing pec");
    ahb(1'b0, pmbsi_pkg::IRQ_OFS, 32'h0);
    chk(rd & 32'h2, 32'h2, "pec irq");
    rdChk(pmbsi_pkg::CMD_OFS, 32'he0, "discarded");
    link(7'h3d, pmbsi_pkg::CMD_SPECIAL_OPTS, 8'h00, 2, 2);
    rdChk(pmbsi_pkg::OPTS_OFS, 32'h80, "bad pec");
    link(7'h3d, pmbsi_pkg::CMD_SPECIAL_OPTS, 8'h00, 2, 1);
    rdChk(pmbsi_pkg::OPTS_OFS, 32'h0, "good pec");
    ahb(1'b0, pmbsi_pkg::IRQ_OFS, 32'h0);
    ahb(1'b1, pmbsi_pkg::CTRL_OFS, 32'h2);
    ahb(1'b0, pmbsi_pkg::STAT_OFS, 32'h0);
    chk(rd & 32'h2, 32'h2, "busy");
    link(7'h3d, pmbsi_pkg::CMD_CLEAR_FAULTS, 8'h0, 1, 0);
    ahb(1'b0, pmbsi_pkg::IRQ_OFS, 32'h0);
    chk(rd & 32'h20, 32'h20, "busy hit");
    repeat (STC) @(posedge core_clk);
    ahb(1'b0, pmbsi_pkg::STAT_OFS, 32'h0);
    chk(rd & 32'h2, 32'h0, "busy end");
    chk(stores, 1, "ctrl store");
    link(7'h3d, pmbsi_pkg::CMD_STORE_USER, 8'h0, 1, 0);
    repeat (STC) @(posedge core_clk);
    chk(stores, 2, "link store");
    tele <= '{vin: 16'h1234, vout: 16'h5678, iout: 16'h9abc, duty: 16'hdef0, temp: 16'h0f1e};
    rdChk(pmbsi_pkg::TELE0_OFS, 32'h56781234, "tele0");
    rdChk(pmbsi_pkg::TELE1_OFS, 32'hdef09abc, "tele1");
    rdChk(pmbsi_pkg::TELE2_OFS, 32'h00000f1e, "tele2");
    chk({29'h0, hresp, sdaOut, alertOut}, 32'h0, "fixed levels");
    results();
  end
endmodule
